/* File: rtl/dsm_pkg.sv */
package dsm_pkg;

    // Data-space map, byte addresses
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] EXT_BASE = 16'h0060;
    localparam logic [15:0] SRAM_BASE = 16'h0100;

    // EEPROM access registers, data-space addresses
    localparam logic [15:0] EE_CTRL_ADR = 16'h003f;
    localparam logic [15:0] EE_DATA_ADR = 16'h0040;
    localparam logic [15:0] EE_ADRL_ADR = 16'h0041;
    localparam logic [15:0] EE_ADRH_ADR = 16'h0042;

    // Control register fields
    localparam int CTL_READ = 0;
    localparam int CTL_STROBE = 1;
    localparam int CTL_ARM = 2;
    localparam int CTL_RIE = 3;
    localparam int CTL_PM = 4;

    // Pointer pairs, low byte register
    localparam logic [4:0] PTR_X = 5'h1a;
    localparam logic [4:0] PTR_Y = 5'h1c;
    localparam logic [4:0] PTR_Z = 5'h1e;

    // Cycle counts: access latency, EEPROM stalls, arm window
    localparam logic [2:0] BASE_LAT = 3'h1;
    localparam logic [2:0] SRAM_LAT = 3'h2;
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] WRITE_STALL = 3'h2;
    localparam logic [2:0] ARM_WINDOW = 3'h4;

    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Programming times
    localparam int CLK_MHZ = 100;
    localparam int T_EW_US = 3400;
    localparam int T_HALF_US = 1800;
    localparam int EW_CYC = T_EW_US * CLK_MHZ;
    localparam int HALF_CYC = T_HALF_US * CLK_MHZ;

    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0,
        AM_IO = 3'h1,
        AM_IND = 3'h2,
        AM_DISP = 3'h3,
        AM_PREDEC = 3'h4,
        AM_POSTINC = 3'h5,
        AM_PMLOAD = 3'h6
    } dsm_am_t;

    typedef enum logic [1:0] {
        PM_ERASE_WRITE = 2'h0,
        PM_ERASE = 2'h1,
        PM_WRITE = 2'h2,
        PM_RSVD = 2'h3
    } dsm_pm_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_ACK = 2'h3
    } dsm_bus_st_t;

endpackage

/* File: rtl/dsm_eeprom.sv */
`timescale 1ns/10ps

module dsm_eeprom
    import dsm_pkg::*;
#(
    parameter int EE_AW = 9,
    parameter int EW_CYCLES = EW_CYC,
    parameter int HALF_CYCLES = HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire dsm_pm_t mode,
    input wire logic [EE_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [EE_AW-1:0] raddr,
    output logic [7:0] rdata,
    output logic busy
);
    localparam int CW = $clog2(EW_CYCLES + 1);

    typedef struct packed {
        logic busy;
        dsm_pm_t op;
        logic [EE_AW-1:0] addr;
        logic [7:0] data;
        logic [CW-1:0] cnt;
    } dsm_ee_st_t;

    dsm_ee_st_t st;
    dsm_ee_st_t next_st;
    dsm_ee_st_t run;
    logic done;
    logic [7:0] mem [2**EE_AW];

    always_comb begin
        run = st;
        done = 1'h0;
        if (st.busy) begin
            if (st.cnt == CW'(1)) begin
                run.busy = 1'h0;
                done = 1'h1;
            end else begin
                run.cnt = st.cnt - CW'(1);
            end
        end else if (start && mode != PM_RSVD) begin
            run.busy = 1'h1;
            run.op = mode;
            run.addr = addr;
            run.data = wdata;
            run.cnt = (mode == PM_ERASE_WRITE) ? CW'(EW_CYCLES)
                                               : CW'(HALF_CYCLES);
        end
        // Reset must not leave a cell half programmed
        if (!rst) begin
            next_st = run;
        end else if (st.busy) begin
            next_st = run;
        end else begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
        rdata <= mem[raddr];
        if (done) begin
            unique case (st.op)
                PM_ERASE_WRITE: mem[st.addr] <= st.data;
                PM_ERASE: mem[st.addr] <= ERASED_BYTE;
                PM_WRITE: mem[st.addr] <= mem[st.addr] & st.data;
                default: ;
            endcase
        end
    end

    assign busy = st.busy;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_reset_no_abort: assert property (
        $past(rst) && $past(st.busy) && $past(st.cnt) > CW'(1) |-> busy
    ) else $error("programming cut short by reset");

    a_prog_length: assert property (
        start && !busy && mode == PM_ERASE |=> st.cnt == CW'(HALF_CYCLES)
    ) else $error("erase-only time loaded wrong");

    c_prog_done: cover property (busy ##1 !busy);

endmodule

/* File: rtl/dsm_core_mem.sv */
`timescale 1ns/10ps

// How it works
// - Program memory is an array of 16-bit words, depth set per variant.
// - Program counter width is the parameter that sizes program memory.
// - Boot and application sections of program memory lock separately.
// - Program-memory load reads a byte anywhere in program memory via Z.
// - Decode: 32 registers, 64 I/O, 160 extended I/O, then SRAM.
// - Extended I/O is reached only by data-space loads and stores.
// - Short-form I/O access carries six address bits, 64 locations.
// - Direct addressing takes any 16-bit data-space address.
// - Displacement adds 0 to 63 to the Y or Z pointer.
// - Pointers are register pairs 26-27, 28-29 and 30-31.
// - Pre-decrement lowers the pointer first; post-increment raises after.
// - Every mode except program-memory load goes through the same data-space decoder.
// - SRAM accesses acknowledge two cycles after being taken.
// - EEPROM is its own byte-wide space of 512 bytes by default.
// - EEPROM address, data and control sit in the standard I/O range.
// - Programming is timed by hardware; its busy bit is readable.
// - A write strobe starts programming only while the arm bit is set.
// - An EEPROM read start holds the acknowledge four extra cycles.
// - An EEPROM write start holds the acknowledge two extra cycles.
// - Reset does not stop programming already under way.
// - Arm bit clears itself four cycles after being set.
// - Mode 00 erase+write 3.4 ms, 01 erase, 10 write 1.8 ms.
// - Mode field writes are ignored while programming is busy.
// - Ready interrupt is a level: enable set and not busy.
module dsm_core_mem
    import dsm_pkg::*;
#(
    parameter int PC_W = 13,
    parameter int BOOT_WORDS = 1024,
    parameter int SRAM_BYTES = 1024,
    parameter int EE_AW = 9,
    parameter int EW_CYCLES = EW_CYC,
    parameter int HALF_CYCLES = HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [0:0] wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dsm_am_t am_mode,
    input wire logic [1:0] am_ptr,
    input wire logic [5:0] am_disp,
    input wire logic pc_load,
    input wire logic pc_step,
    input wire logic [PC_W-1:0] pc_value,
    output logic [PC_W-1:0] pc,
    output logic [15:0] instr,
    input wire logic pm_we,
    input wire logic [PC_W-1:0] pm_waddr,
    input wire logic [15:0] pm_wdata,
    input wire logic boot_lock,
    input wire logic app_lock,
    output logic eeprom_ready_irq
);
    localparam int PM_WORDS = 2 ** PC_W;
    // SRAM size a power of two of at least 256, so low bits index it
    localparam int SA_W = $clog2(SRAM_BYTES);
    localparam logic [15:0] SRAM_END = SRAM_BASE + 16'(SRAM_BYTES);
    localparam logic [PC_W-1:0] BOOT_START = PC_W'(PM_WORDS - BOOT_WORDS);

    typedef struct packed {
        dsm_bus_st_t bus;
        logic [2:0] cnt;
        logic ack;
        logic [7:0] rdata;
        logic [15:0] ea;
        dsm_am_t mode;
        logic [4:0] base;
        logic [15:0] ptr;
        logic we;
        logic [7:0] wdata;
        logic armed;
        logic eeprom_write_arm;
        logic [2:0] arm_cnt;
        logic eeprom_ready_irq_enable;
        dsm_pm_t eeprom_prog_mode;
        logic [7:0] ee_data;
        logic [EE_AW-1:0] ee_addr;
        logic [PC_W-1:0] pc;
        logic [15:0] instr;
    } dsm_state_t;

    dsm_state_t st;
    dsm_state_t next_st;

    logic [7:0] regs [32];
    logic [7:0] sram [SRAM_BYTES];
    logic [15:0] pmem [PM_WORDS];

    logic take;
    logic commit;
    logic we_c;
    logic ctrl_wr_c;
    logic sram_c;
    logic pm_locked;
    logic ee_busy;
    logic ee_start;
    logic [7:0] ee_rdata;
    logic [4:0] base_c;
    logic [15:0] ptr_c;
    logic [15:0] ea_c;
    logic [15:0] newptr_c;
    logic [15:0] rd_ea;
    logic rd_pml;
    logic [15:0] pm_word;
    logic [7:0] rd_c;
    logic [2:0] lat_c;

    ////////////////////////////////////////////////
    // Address generation

    assign take = st.bus == ST_IDLE && wb_cyc_i && wb_stb_i;
    assign commit = st.ack;
    // Program memory is never written through the data port
    assign we_c = wb_we_i && wb_sel_i[0] && am_mode != AM_PMLOAD;

    always_comb begin
        unique case (am_ptr)
            2'h0: base_c = PTR_X;
            2'h1: base_c = PTR_Y;
            default: base_c = PTR_Z;
        endcase
        if (am_mode == AM_DISP) begin
            base_c = am_ptr[1] ? PTR_Z : PTR_Y;
        end
        if (am_mode == AM_PMLOAD) begin
            base_c = PTR_Z;
        end
        ptr_c = {regs[base_c + 5'h1], regs[base_c]};
        newptr_c = ptr_c;
        unique case (am_mode)
            AM_DIRECT: ea_c = wb_adr_i;
            AM_IO: ea_c = IO_BASE + {10'h0, wb_adr_i[5:0]};
            AM_DISP: ea_c = ptr_c + {10'h0, am_disp};
            AM_PREDEC: begin
                ea_c = ptr_c - 16'h1;
                newptr_c = ea_c;
            end
            AM_POSTINC: begin
                ea_c = ptr_c;
                newptr_c = ptr_c + 16'h1;
            end
            default: ea_c = ptr_c;
        endcase
    end

    ////////////////////////////////////////////////
    // Data-space decode and latency

    assign sram_c = ea_c >= SRAM_BASE && ea_c < SRAM_END
                    && am_mode != AM_PMLOAD;
    assign ctrl_wr_c = we_c && ea_c == EE_CTRL_ADR;

    always_comb begin
        lat_c = BASE_LAT;
        if (sram_c) begin
            lat_c = SRAM_LAT;
        end
        if (ctrl_wr_c && wb_dat_i[CTL_READ] && !ee_busy) begin
            lat_c = BASE_LAT + READ_STALL;
        end else if (ctrl_wr_c && wb_dat_i[CTL_STROBE] && st.eeprom_write_arm
                     && !ee_busy) begin
            lat_c = BASE_LAT + WRITE_STALL;
        end
    end

    // Read path shared by every mode
    always_comb begin
        rd_ea = (st.bus == ST_IDLE) ? ea_c : st.ea;
        rd_pml = (st.bus == ST_IDLE) ? am_mode == AM_PMLOAD
                                     : st.mode == AM_PMLOAD;
        pm_word = pmem[rd_ea[PC_W:1]];
        if (rd_pml) begin
            rd_c = rd_ea[0] ? pm_word[15:8] : pm_word[7:0];
        end else if (rd_ea < IO_BASE) begin
            rd_c = regs[rd_ea[4:0]];
        end else if (rd_ea == EE_CTRL_ADR) begin
            rd_c = {2'h0, st.eeprom_prog_mode, st.eeprom_ready_irq_enable,
                    st.eeprom_write_arm, ee_busy, 1'h0};
        end else if (rd_ea == EE_DATA_ADR) begin
            rd_c = st.ee_data;
        end else if (rd_ea == EE_ADRL_ADR) begin
            rd_c = st.ee_addr[7:0];
        end else if (rd_ea == EE_ADRH_ADR) begin
            rd_c = 8'(st.ee_addr >> 8);
        end else if (rd_ea >= SRAM_BASE && rd_ea < SRAM_END) begin
            rd_c = sram[rd_ea[SA_W-1:0]];
        end else begin
            // Other I/O, extended I/O and unmapped read as zero
            rd_c = 8'h0;
        end
    end

    ////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        ee_start = 1'h0;
        if (st.arm_cnt == 3'h1) begin
            next_st.eeprom_write_arm = 1'h0;
        end
        if (st.arm_cnt != 3'h0) begin
            next_st.arm_cnt = st.arm_cnt - 3'h1;
        end
        if (pc_load) begin
            next_st.pc = pc_value;
        end else if (pc_step) begin
            next_st.pc = st.pc + PC_W'(1);
        end
        next_st.instr = pmem[st.pc];
        unique case (st.bus)
            ST_IDLE: begin
                if (take) begin
                    next_st.ea = ea_c;
                    next_st.mode = am_mode;
                    next_st.base = base_c;
                    next_st.ptr = newptr_c;
                    next_st.we = we_c;
                    next_st.wdata = wb_dat_i;
                    // Arm window judged when the strobe write is taken
                    next_st.armed = st.eeprom_write_arm;
                    if (lat_c == BASE_LAT) begin
                        next_st.ack = 1'h1;
                        next_st.rdata = rd_c;
                        next_st.bus = ST_ACK;
                    end else begin
                        next_st.cnt = lat_c - 3'h2;
                        next_st.bus = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (st.cnt == 3'h0) begin
                    next_st.ack = 1'h1;
                    next_st.rdata = rd_c;
                    next_st.bus = ST_ACK;
                end else begin
                    next_st.cnt = st.cnt - 3'h1;
                end
            end
            ST_ACK: begin
                next_st.ack = 1'h0;
                next_st.bus = ST_IDLE;
                if (st.we && st.ea == EE_CTRL_ADR) begin
                    next_st.eeprom_ready_irq_enable = st.wdata[CTL_RIE];
                    if (!ee_busy) begin
                        next_st.eeprom_prog_mode =
                            dsm_pm_t'(st.wdata[CTL_PM +: 2]);
                    end
                    if (st.wdata[CTL_ARM]) begin
                        next_st.eeprom_write_arm = 1'h1;
                        next_st.arm_cnt = ARM_WINDOW;
                    end
                    if (st.wdata[CTL_STROBE] && st.armed && !ee_busy) begin
                        ee_start = 1'h1;
                    end
                    if (st.wdata[CTL_READ] && !ee_busy) begin
                        next_st.ee_data = ee_rdata;
                    end
                end
                if (st.we && st.ea == EE_DATA_ADR) begin
                    next_st.ee_data = st.wdata;
                end
                if (st.we && st.ea == EE_ADRL_ADR) begin
                    next_st.ee_addr[7:0] = st.wdata;
                end
                if (st.we && st.ea == EE_ADRH_ADR) begin
                    next_st.ee_addr = EE_AW'({st.wdata, st.ee_addr[7:0]});
                end
            end
            default: next_st.bus = ST_IDLE;
        endcase
        if (rst) begin
            next_st = '0;
            // Mode survives a reset that lands mid-programming
            next_st.eeprom_prog_mode = ee_busy ? st.eeprom_prog_mode
                                               : PM_ERASE_WRITE;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////
    // Storage

    assign pm_locked = (pm_waddr >= BOOT_START) ? boot_lock
                                                 : app_lock;

    always_ff @(posedge clk_sys) begin
        if (commit && st.we) begin
            if (st.ea < IO_BASE) begin
                regs[st.ea[4:0]] <= st.wdata;
            end else if (st.ea >= SRAM_BASE && st.ea < SRAM_END) begin
                sram[st.ea[SA_W-1:0]] <= st.wdata;
            end
        end
        // Pointer update lands last, so it wins over a same-pair store
        if (commit && (st.mode == AM_PREDEC || st.mode == AM_POSTINC)) begin
            regs[st.base] <= st.ptr[7:0];
            regs[st.base + 5'h1] <= st.ptr[15:8];
        end
        if (pm_we && !pm_locked) begin
            pmem[pm_waddr] <= pm_wdata;
        end
    end

    dsm_eeprom #(
        .EE_AW(EE_AW),
        .EW_CYCLES(EW_CYCLES),
        .HALF_CYCLES(HALF_CYCLES)
    ) u_eeprom (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(ee_start),
        .mode(dsm_pm_t'(st.wdata[CTL_PM +: 2])),
        .addr(st.ee_addr),
        .wdata(st.ee_data),
        .raddr(st.ee_addr),
        .rdata(ee_rdata),
        .busy(ee_busy)
    );

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign pc = st.pc;
    assign instr = st.instr;
    assign eeprom_ready_irq = st.eeprom_ready_irq_enable && !ee_busy;

    ////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_sram_two_cycles: assert property (
        take && sram_c |=> !wb_ack_o ##1 wb_ack_o
    ) else $error("SRAM access not answered in two cycles");

    a_ee_read_stall: assert property (
        take && ctrl_wr_c && wb_dat_i[CTL_READ] && !ee_busy
        |=> !wb_ack_o [*4] ##1 wb_ack_o
    ) else $error("EEPROM read stall is not four cycles");

    a_ee_write_stall: assert property (
        take && ctrl_wr_c && !wb_dat_i[CTL_READ] && wb_dat_i[CTL_STROBE]
        && st.eeprom_write_arm && !ee_busy && !sram_c
        // Reserved mode still stalls, but must never start programming
        |=> !wb_ack_o [*2] ##1 wb_ack_o
        ##1 (ee_busy || st.wdata[CTL_PM +: 2] == PM_RSVD)
    ) else $error("EEPROM write stall or start wrong");

    a_arm_clears: assert property (
        $rose(st.eeprom_write_arm)
        |-> st.eeprom_write_arm [*4] ##1 (!st.eeprom_write_arm || $past(commit))
    ) else $error("arm bit window is not four cycles");

    a_mode_frozen: assert property (
        ee_busy |=> $stable(st.eeprom_prog_mode)
    ) else $error("mode changed while programming");

    a_ready_level: assert property (
        $fell(ee_busy) && st.eeprom_ready_irq_enable |-> eeprom_ready_irq
    ) else $error("ready interrupt missing after programming");

    a_guarded_write: assert property (
        commit && st.we && st.ea == EE_CTRL_ADR && st.wdata[CTL_STROBE]
        && !st.armed && !ee_busy |=> !ee_busy
    ) else $error("EEPROM write started without arming");

    a_post_increment: assert property (
        commit && st.mode == AM_POSTINC
        |=> {regs[st.base + 5'h1], regs[st.base]} == st.ea + 16'h1
    ) else $error("post-increment pointer wrong");

    a_pre_decrement: assert property (
        commit && st.mode == AM_PREDEC
        |=> {regs[st.base + 5'h1], regs[st.base]} == st.ea
    ) else $error("pre-decrement pointer wrong");

    a_io_window: assert property (
        take && am_mode == AM_IO |-> ea_c >= IO_BASE && ea_c < EXT_BASE
    ) else $error("short I/O form left the 64-entry window");

    a_disp_reach: assert property (
        take && am_mode == AM_DISP |-> ea_c - ptr_c <= 16'h3f
    ) else $error("displacement beyond 63");

    c_sram_read: cover property (take && sram_c && !we_c);
    c_ee_write: cover property (ee_start);
    c_ee_read: cover property (take && ctrl_wr_c && wb_dat_i[CTL_READ]);
    c_predec: cover property (commit && st.mode == AM_PREDEC);

endmodule

/* File: sim/dsm_core_model.sv */
`timescale 1ns/10ps

module dsm_core_model
    import dsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic wb_ack_o,
    input wire logic [7:0] wb_dat_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [15:0] wb_adr_i,
    output logic [0:0] wb_sel_i,
    output logic [7:0] wb_dat_i,
    output dsm_am_t am_mode,
    output logic [1:0] am_ptr,
    output logic [5:0] am_disp
);
    int lat;
    logic [7:0] rd;

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 4'h0;
        wb_adr_i = 16'h0000;
        wb_dat_i = 8'h00;
        am_mode = AM_DIRECT;
        am_ptr = 2'h0;
        am_disp = 6'h00;
    end

    // Bound stands in for a hung slave; caller judges lat
    task automatic xfer(input logic we, input dsm_am_t m,
        input logic [15:0] a, input logic [7:0] d,
        input logic [1:0] p, input logic [5:0] ds);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 1'b1;
        wb_adr_i <= a;
        wb_dat_i <= d;
        am_mode <= m;
        am_ptr <= p;
        am_disp <= ds;
        lat = 0;
        do begin
            @(posedge clk_sys);
            lat++;
        end while (wb_ack_o !== 1'b1 && lat < 400);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Arm, then strobe on the very next access, well inside the window
    task automatic ee_start(input logic [7:0] ctl);
        xfer(1'b1, AM_DIRECT, EE_CTRL_ADR, (ctl & 8'hfd) | 8'h04, 2'h0,
            6'h00);
        xfer(1'b1, AM_DIRECT, EE_CTRL_ADR, ctl, 2'h0, 6'h00);
    endtask
endmodule

/* File: sim/dsm_core_mem_tb.sv */
`timescale 1ns/10ps

module dsm_core_mem_tb
    import dsm_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, eeprom_ready_irq;
    logic [0:0] wb_sel_i;
    logic [15:0] wb_adr_i, instr, pm_wdata;
    logic [7:0] wb_dat_i, wb_dat_o, v, x, prev;
    dsm_am_t am_mode;
    logic [1:0] am_ptr;
    logic [5:0] am_disp;
    logic pc_load, pc_step, pm_we, boot_lock, app_lock;
    logic [12:0] pc, pc_value, pm_waddr;
    logic [8:0] q[$];
    logic [8:0] note;
    int mismatches, tests_run, i;

    dsm_core_mem #(.SRAM_BYTES(512), .EW_CYCLES(20), .HALF_CYCLES(10)) uut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .am_mode(am_mode), .am_ptr(am_ptr),
        .am_disp(am_disp), .pc_load(pc_load), .pc_step(pc_step),
        .pc_value(pc_value), .pc(pc), .instr(instr), .pm_we(pm_we),
        .pm_waddr(pm_waddr), .pm_wdata(pm_wdata), .boot_lock(boot_lock),
        .app_lock(app_lock), .eeprom_ready_irq(eeprom_ready_irq)
    );

    dsm_core_model core (
        .clk_sys(clk_sys), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .am_mode(am_mode), .am_ptr(am_ptr), .am_disp(am_disp)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Note is queued before the request, so the monitor never runs dry
    task automatic acc(input logic we, input dsm_am_t m,
        input logic [15:0] a, input logic [7:0] d, input int n,
        input logic [8:0] e, input logic [1:0] p = 2'h0,
        input logic [5:0] ds = 6'h00);
        if (!we) q.push_back(e);
        core.xfer(we, m, a, d, p, ds);
        if (core.lat >= 400) begin
            mismatches++;
            stop_test();
        end
        cmp(16'(core.lat - 1), 16'(n));
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
        acc(1'b1, AM_DIRECT, a, d, n, 9'h000);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input int n);
        acc(1'b0, AM_DIRECT, a, 8'h00, n, {1'b1, e});
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 100; k++) begin
            acc(1'b0, AM_DIRECT, EE_CTRL_ADR, 8'h00, 1, 9'h000);
            if (core.rd[1] === 1'b0) break;
        end
        cmp(16'(core.rd[1]), 16'h0000);
        // Still busy after the bound: give up rather than hang
        if (core.rd[1] !== 1'b0) stop_test();
    endtask

    task automatic pmw(input logic [12:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        pm_we <= 1'b1;
        pm_waddr <= a;
        pm_wdata <= d;
        @(posedge clk_sys);
        pm_we <= 1'b0;
    endtask

    // Fetch lags the counter by one cycle
    task automatic pmchk(input logic [12:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        pc_load <= 1'b1;
        pc_value <= a;
        @(posedge clk_sys);
        pc_load <= 1'b0;
        @(posedge clk_sys);
        #1;
        cmp(16'(pc), 16'(a));
        cmp(instr, e);
    endtask

    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            note = q.pop_front();
            if (note[8]) cmp({8'h00, wb_dat_o}, {8'h00, note[7:0]});
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {pc_load, pc_step, pm_we, boot_lock, app_lock} = 5'h00;
        pc_value = 13'h0000;
        pm_waddr = 13'h0000;
        pm_wdata = 16'h0000;
        mismatches = 0;
        tests_run = 0;
        i = $urandom(32'h6125);
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        v = 8'($urandom);
        wr(16'h0005, v, 1);
        rdc(16'h0005, v, 1);
        wr(16'h0100, ~v, 2);
        wr(16'h02ff, v, 2);
        rdc(16'h0100, ~v, 2);
        rdc(16'h02ff, v, 2);
        rdc(16'h0060, 8'h00, 1);
        rdc(16'h0300, 8'h00, 1);
        wr(16'h001a, 8'h10, 1);
        wr(16'h001b, 8'h01, 1);
        acc(1'b1, AM_POSTINC, 16'h0, v, 2, 9'h0, 2'h0);
        rdc(16'h001a, 8'h11, 1);
        rdc(16'h0110, v, 2);
        acc(1'b0, AM_PREDEC, 16'h0, 8'h0, 2, {1'b1, v}, 2'h0);
        rdc(16'h001a, 8'h10, 1);
        wr(16'h001c, 8'h00, 1);
        wr(16'h001d, 8'h01, 1);
        acc(1'b1, AM_DISP, 16'h0, ~v, 2, 9'h0, 2'h1, 6'h3f);
        rdc(16'h013f, ~v, 2);
        wr(16'h001e, 8'h05, 1);
        wr(16'h001f, 8'h00, 1);
        acc(1'b0, AM_IND, 16'h0, 8'h0, 1, {1'b1, v}, 2'h2);
        acc(1'b1, AM_IO, 16'h0020, ~v, 1, 9'h0);
        rdc(EE_DATA_ADR, ~v, 1);
        pmw(13'h0005, {v, ~v});
        pmw(13'h1fff, 16'h5a3c);
        boot_lock <= 1'b1;
        app_lock <= 1'b1;
        pmw(13'h1fff, 16'ha5c3);
        pmw(13'h0005, 16'h1234);
        pmchk(13'h1fff, 16'h5a3c);
        // Stepping past the top word wraps to zero
        @(posedge clk_sys);
        pc_step <= 1'b1;
        @(posedge clk_sys);
        pc_step <= 1'b0;
        #1;
        cmp(16'(pc), 16'h0000);
        pmchk(13'h0005, {v, ~v});
        wr(16'h001e, 8'h0b, 1);
        acc(1'b0, AM_PMLOAD, 16'h0, 8'h0, 1, {1'b1, v}, 2'h2);
        wr(EE_ADRL_ADR, 8'h05, 1);
        wr(EE_ADRH_ADR, 8'h01, 1);
        wr(EE_DATA_ADR, v, 1);
        core.ee_start(8'h0a);
        cmp(16'(core.lat - 1), 16'h0003);
        rdc(EE_CTRL_ADR, 8'h0a, 1);
        cmp(16'(eeprom_ready_irq), 16'h0000);
        wr(EE_CTRL_ADR, 8'h38, 1);
        rdc(EE_CTRL_ADR, 8'h0a, 1);
        wait_idle();
        cmp(16'(eeprom_ready_irq), 16'h0001);
        wr(EE_CTRL_ADR, 8'h09, 5);
        rdc(EE_DATA_ADR, v, 1);
        prev = v;
        for (i = 1; i < 4; i++) begin
            x = 8'($urandom) & 8'h7f;
            wr(EE_DATA_ADR, x, 1);
            core.ee_start({2'h0, 2'(i), 4'ha});
            cmp(16'(core.lat - 1), 16'h0003);
            wait_idle();
            prev = (i == 1) ? 8'hff : (i == 2) ? (prev & x) : prev;
            wr(EE_CTRL_ADR, 8'h01, 5);
            rdc(EE_DATA_ADR, prev, 1);
        end
        wr(EE_CTRL_ADR, 8'h02, 1);
        rdc(EE_CTRL_ADR, 8'h00, 1);
        core.ee_start(8'h12);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(EE_CTRL_ADR, 8'h12, 1);
        wr(EE_ADRL_ADR, 8'h05, 1);
        wr(EE_ADRH_ADR, 8'h01, 1);
        wait_idle();
        wr(EE_CTRL_ADR, 8'h01, 5);
        rdc(EE_DATA_ADR, 8'hff, 1);
        stop_test();
    end
endmodule
